// *** src/ulc_pkg.sv ***
package ulc_pkg;

    // Register map, byte addresses on the APB word grid
    localparam logic [11:0] ADDR_DATA = 12'h000;
    localparam logic [11:0] ADDR_FLAGS = 12'h018;
    localparam logic [11:0] ADDR_IBRD = 12'h024;
    localparam logic [11:0] ADDR_FBRD = 12'h028;
    localparam logic [11:0] ADDR_LCRH = 12'h02c;
    localparam logic [11:0] ADDR_CR = 12'h030;

    // Values after reset
    localparam logic [7:0] LCRH_RST = 8'h00;
    localparam logic [15:0] IBRD_RST = 16'h0000;
    localparam logic [5:0] FBRD_RST = 6'h00;
    localparam logic [15:0] CR_RST = 16'h0300;
    localparam logic [15:0] CR_MASK = 16'hff87;

    // Line control fields
    localparam int LCRH_BRK = 0;
    localparam int LCRH_PEN = 1;
    localparam int LCRH_EPS = 2;
    localparam int LCRH_TWO_STOP_SELECT = 3;
    localparam int LCRH_FEN = 4;
    localparam int LCRH_WORD_LENGTH_SELECT = 5;
    localparam int LCRH_SPS = 7;

    // Control fields
    localparam int CR_UARTEN = 0;
    localparam int CR_TXE = 8;
    localparam int CR_RXE = 9;
    localparam int CR_RTS = 11;
    localparam int CR_REQUEST_TO_SEND_FLOW_ENABLE = 14;
    localparam int CR_CLEAR_TO_SEND_FLOW_ENABLE = 15;

    // Sixteen ticks per bit, sampled in the middle
    localparam logic [3:0] TICK_LAST = 4'hf;
    localparam logic [3:0] TICK_MID = 4'h7;

    localparam int FIFO_DEPTH = 8;
    localparam int TX_W = 8;
    localparam int RX_W = 10;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP1, TX_STOP2, TX_BREAK
    } ulc_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
    } ulc_rx_state_t;

    function automatic logic ulc_parity(input logic [7:0] d,
                                        input logic [1:0] word_length_select,
                                        input logic even_parity_select,
                                        input logic stick_parity_select);
        logic p;
        p = ^(d & (8'hff >> (2'h3 - word_length_select)));
        if (stick_parity_select) begin
            ulc_parity = ~even_parity_select;
        end else begin
            ulc_parity = even_parity_select ? p : ~p;
        end
    endfunction

    function automatic logic ulc_mapped(input logic [11:0] a);
        ulc_mapped = (a == ADDR_DATA) || (a == ADDR_FLAGS) ||
                     (a == ADDR_IBRD) || (a == ADDR_FBRD) ||
                     (a == ADDR_LCRH) || (a == ADDR_CR);
    endfunction

endpackage

// *** src/ulc_fifo_if.sv ***
`timescale 1ns/1ps
interface ulc_fifo_if #(parameter int WIDTH = 8, parameter int DEPTH = 8);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    logic [$clog2(DEPTH):0] level;
    modport fifo (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data, level);
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data, level);
endinterface

// *** src/ulc_fifo.sv ***
`timescale 1ns/1ps
// DEPTH must be a power of two; pointers wrap by width
module ulc_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 8) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic single_mode,
    ulc_fifo_if.fifo port_if
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } ulc_fifo_state_t;

    ulc_fifo_state_t st_reg;
    ulc_fifo_state_t st_next;
    logic do_push;
    logic do_pop;

    // Character mode: one-deep holding register
    assign port_if.in_ready = single_mode ? (st_reg.count == '0) :
                              (st_reg.count != (AW+1)'(DEPTH));
    assign port_if.out_valid = (st_reg.count != '0);
    assign port_if.out_data = st_reg.mem[st_reg.rptr];
    assign port_if.level = st_reg.count;

    always_comb begin
        st_next = st_reg;
        do_push = port_if.in_valid && port_if.in_ready;
        do_pop = port_if.out_ready && port_if.out_valid;
        if (do_push) begin
            st_next.mem[st_reg.wptr] = port_if.in_data;
            st_next.wptr = st_reg.wptr + 1'h1;
        end
        if (do_pop) begin
            st_next.rptr = st_reg.rptr + 1'h1;
        end
        if (do_push && !do_pop) begin
            st_next.count = st_reg.count + 1'h1;
        end else if (do_pop && !do_push) begin
            st_next.count = st_reg.count - 1'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// *** src/ulc_line_control.sv ***
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module ulc_line_control
    import ulc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_rx_in,
    input wire logic clear_to_send_input_n,
    output logic serial_tx_out,
    output logic request_to_send_out_n
);

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic txd;
        logic rts_n;
        logic [2:0] rx_sync;
        logic rx_filt;
        logic [2:0] cts_sync;
        logic cts_filt;
        logic [7:0] lcrh;
        logic [15:0] ibrd;
        logic [5:0] fbrd;
        logic [15:0] ibrd_stage;
        logic [5:0] fbrd_stage;
        logic [15:0] cr;
        logic [15:0] baud_cnt;
        logic [5:0] frac_acc;
        logic tick;
        ulc_tx_state_t tx_state;
        logic [3:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] tx_char;
        logic tx_pop;
        logic tx_push;
        logic [7:0] tx_wdata;
        ulc_rx_state_t rx_state;
        logic [3:0] rx_tick;
        logic [2:0] rx_bit;
        logic [7:0] rx_shift;
        logic rx_perr;
        logic rx_push;
        logic [RX_W-1:0] rx_word;
        logic rx_pop;
    } ulc_state_t;

    ulc_state_t st_reg;
    ulc_state_t st_next;

    ulc_fifo_if #(.WIDTH(TX_W), .DEPTH(FIFO_DEPTH)) tx_if ();
    ulc_fifo_if #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH)) rx_if ();

    logic apb_done;
    logic apb_wait;
    logic carry;
    logic [2:0] last_bit;
    logic tx_bit_end;
    logic rx_mid;
    logic en_tx;
    logic en_rx;
    logic cts_ok;
    logic rxd;

    ulc_fifo #(.WIDTH(TX_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .single_mode(!st_reg.lcrh[LCRH_FEN]),
        .port_if(tx_if.fifo)
    );

    ulc_fifo #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .single_mode(!st_reg.lcrh[LCRH_FEN]),
        .port_if(rx_if.fifo)
    );

    assign tx_if.in_valid = st_reg.tx_push;
    assign tx_if.in_data = st_reg.tx_wdata;
    assign tx_if.out_ready = st_reg.tx_pop;
    assign rx_if.in_valid = st_reg.rx_push;
    assign rx_if.in_data = st_reg.rx_word;
    assign rx_if.out_ready = st_reg.rx_pop;

    assign apb_done = psel && penable && st_reg.pready;
    assign apb_wait = psel && penable && !st_reg.pready;

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign serial_tx_out = st_reg.txd;
    assign request_to_send_out_n = st_reg.rts_n;

    always_comb begin
        st_next = st_reg;
        carry = 1'h0;
        last_bit = 3'h4 + {1'h0, st_reg.lcrh[LCRH_WORD_LENGTH_SELECT +: 2]};
        tx_bit_end = st_reg.tick && (st_reg.tx_tick == TICK_LAST);
        rx_mid = st_reg.tick && (st_reg.rx_tick == TICK_MID);
        en_tx = st_reg.cr[CR_UARTEN] && st_reg.cr[CR_TXE];
        en_rx = st_reg.cr[CR_UARTEN] && st_reg.cr[CR_RXE];
        cts_ok = !st_reg.cr[CR_CLEAR_TO_SEND_FLOW_ENABLE] || !st_reg.cts_filt;
        rxd = st_reg.rx_filt;
        st_next.tx_push = 1'h0;
        st_next.tx_pop = 1'h0;
        st_next.rx_push = 1'h0;
        st_next.rx_pop = 1'h0;

        // Pin inputs: a change counts once stages two and three agree
        st_next.rx_sync = {st_reg.rx_sync[1:0], serial_rx_in};
        st_next.cts_sync = {st_reg.cts_sync[1:0], clear_to_send_input_n};
        if (st_reg.rx_sync[1] == st_reg.rx_sync[2]) begin
            st_next.rx_filt = st_reg.rx_sync[2];
        end
        if (st_reg.cts_sync[1] == st_reg.cts_sync[2]) begin
            st_next.cts_filt = st_reg.cts_sync[2];
        end

        // APB: one wait cycle so read data leaves a flop
        st_next.pready = apb_wait;
        st_next.pslverr = apb_wait && !ulc_mapped(paddr);
        if (apb_wait) begin
            if (paddr == ADDR_DATA) begin
                st_next.prdata = rx_if.out_valid ?
                                 {22'h0, rx_if.out_data} : 32'h0;
            end else if (paddr == ADDR_FLAGS) begin
                st_next.prdata = {24'h0, !tx_if.out_valid, !rx_if.in_ready,
                                  !tx_if.in_ready, !rx_if.out_valid,
                                  (st_reg.tx_state != TX_IDLE) ||
                                  tx_if.out_valid,
                                  2'h0, !st_reg.cts_filt};
            end else if (paddr == ADDR_IBRD) begin
                st_next.prdata = {16'h0, st_reg.ibrd_stage};
            end else if (paddr == ADDR_FBRD) begin
                st_next.prdata = {26'h0, st_reg.fbrd_stage};
            end else if (paddr == ADDR_LCRH) begin
                st_next.prdata = {24'h0, st_reg.lcrh};
            end else if (paddr == ADDR_CR) begin
                st_next.prdata = {16'h0, st_reg.cr};
            end else begin
                st_next.prdata = 32'h0;
            end
        end
        if (apb_done && pwrite) begin
            if (paddr == ADDR_DATA) begin
                st_next.tx_push = 1'h1;
                st_next.tx_wdata = pwdata[7:0];
            end else if (paddr == ADDR_IBRD) begin
                st_next.ibrd_stage = pwdata[15:0];
            end else if (paddr == ADDR_FBRD) begin
                st_next.fbrd_stage = pwdata[5:0];
            end else if (paddr == ADDR_LCRH) begin
                st_next.lcrh = pwdata[7:0];
                st_next.ibrd = st_reg.ibrd_stage;
                st_next.fbrd = st_reg.fbrd_stage;
            end else if (paddr == ADDR_CR) begin
                st_next.cr = pwdata[15:0] & CR_MASK;
            end
        end
        if (apb_done && !pwrite && paddr == ADDR_DATA) begin
            st_next.rx_pop = rx_if.out_valid;
        end

        // Sixteen-times bit clock; zero divisor stops it
        st_next.tick = 1'h0;
        if (!st_reg.cr[CR_UARTEN] || st_reg.ibrd == 16'h0) begin
            st_next.baud_cnt = 16'h0;
        end else if (st_reg.baud_cnt == 16'h0) begin
            {carry, st_next.frac_acc} = {1'h0, st_reg.frac_acc} +
                                        {1'h0, st_reg.fbrd};
            st_next.baud_cnt = st_reg.ibrd - 16'h1 + {15'h0, carry};
            st_next.tick = 1'h1;
        end else begin
            st_next.baud_cnt = st_reg.baud_cnt - 16'h1;
        end

        // Transmitter; break and new starts only between characters
        if (st_reg.tick) begin
            st_next.tx_tick = st_reg.tx_tick + 4'h1;
        end
        case (st_reg.tx_state)
            TX_IDLE: begin
                if (st_reg.lcrh[LCRH_BRK]) begin
                    st_next.tx_state = TX_BREAK;
                end else if (en_tx && cts_ok && st_reg.tick &&
                             tx_if.out_valid) begin
                    st_next.tx_char = tx_if.out_data;
                    st_next.tx_pop = 1'h1;
                    st_next.tx_tick = 4'h0;
                    st_next.tx_state = TX_START;
                end
            end
            TX_START: begin
                if (tx_bit_end) begin
                    st_next.tx_bit = 3'h0;
                    st_next.tx_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_bit_end) begin
                    if (st_reg.tx_bit == last_bit) begin
                        st_next.tx_state = st_reg.lcrh[LCRH_PEN] ?
                                           TX_PARITY : TX_STOP1;
                    end else begin
                        st_next.tx_bit = st_reg.tx_bit + 3'h1;
                    end
                end
            end
            TX_PARITY: begin
                if (tx_bit_end) begin
                    st_next.tx_state = TX_STOP1;
                end
            end
            TX_STOP1: begin
                if (tx_bit_end) begin
                    st_next.tx_state = st_reg.lcrh[LCRH_TWO_STOP_SELECT] ?
                                       TX_STOP2 : TX_IDLE;
                end
            end
            TX_STOP2: begin
                if (tx_bit_end) begin
                    st_next.tx_state = TX_IDLE;
                end
            end
            TX_BREAK: begin
                if (!st_reg.lcrh[LCRH_BRK]) begin
                    st_next.tx_state = TX_IDLE;
                end
            end
            default: begin
                st_next.tx_state = TX_IDLE;
            end
        endcase

        // Line level follows the next state so pin and state agree
        case (st_next.tx_state)
            TX_START: st_next.txd = 1'h0;
            TX_DATA: st_next.txd = st_next.tx_char[st_next.tx_bit];
            TX_PARITY: st_next.txd = ulc_parity(st_next.tx_char,
                                                st_reg.lcrh[LCRH_WORD_LENGTH_SELECT +: 2],
                                                st_reg.lcrh[LCRH_EPS],
                                                st_reg.lcrh[LCRH_SPS]);
            TX_BREAK: st_next.txd = 1'h0;
            default: st_next.txd = 1'h1;
        endcase

        // Receiver; stop bit sampled once whatever the stop setting
        if (st_reg.tick) begin
            st_next.rx_tick = st_reg.rx_tick + 4'h1;
        end
        case (st_reg.rx_state)
            RX_IDLE: begin
                if (en_rx && st_reg.tick && !rxd) begin
                    st_next.rx_tick = 4'h0;
                    st_next.rx_shift = 8'h00;
                    st_next.rx_perr = 1'h0;
                    st_next.rx_state = RX_START;
                end
            end
            RX_START: begin
                if (rx_mid) begin
                    st_next.rx_bit = 3'h0;
                    st_next.rx_state = rxd ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_mid) begin
                    st_next.rx_shift[st_reg.rx_bit] = rxd;
                    if (st_reg.rx_bit == last_bit) begin
                        st_next.rx_state = st_reg.lcrh[LCRH_PEN] ?
                                           RX_PARITY : RX_STOP;
                    end else begin
                        st_next.rx_bit = st_reg.rx_bit + 3'h1;
                    end
                end
            end
            RX_PARITY: begin
                if (rx_mid) begin
                    st_next.rx_perr = rxd != ulc_parity(st_reg.rx_shift,
                                      st_reg.lcrh[LCRH_WORD_LENGTH_SELECT +: 2],
                                      st_reg.lcrh[LCRH_EPS],
                                      st_reg.lcrh[LCRH_SPS]);
                    st_next.rx_state = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_mid) begin
                    // Full receive FIFO drops the character
                    st_next.rx_push = 1'h1;
                    st_next.rx_word = {!rxd, st_reg.rx_perr,
                                       st_reg.rx_shift};
                    st_next.rx_state = RX_IDLE;
                end
            end
            default: begin
                st_next.rx_state = RX_IDLE;
            end
        endcase

        st_next.rts_n = st_reg.cr[CR_REQUEST_TO_SEND_FLOW_ENABLE] ? !rx_if.in_ready :
                        !st_reg.cr[CR_RTS];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.txd <= 1'h1;
            st_reg.rts_n <= 1'h1;
            st_reg.rx_sync <= 3'h7;
            st_reg.rx_filt <= 1'h1;
            st_reg.cts_sync <= 3'h7;
            st_reg.cts_filt <= 1'h1;
            st_reg.lcrh <= LCRH_RST;
            st_reg.ibrd <= IBRD_RST;
            st_reg.fbrd <= FBRD_RST;
            st_reg.ibrd_stage <= IBRD_RST;
            st_reg.fbrd_stage <= FBRD_RST;
            st_reg.cr <= CR_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    logic post_rst;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            post_rst <= 1'h0;
        end else begin
            post_rst <= 1'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence sq_data_end;
        (st_reg.tx_state == TX_DATA) ##1 (st_reg.tx_state != TX_DATA);
    endsequence

    sequence sq_stop1_end;
        (st_reg.tx_state == TX_STOP1) ##1 (st_reg.tx_state != TX_STOP1);
    endsequence

    AST_SINGLE_DEPTH: assert property (
        (!st_reg.lcrh[LCRH_FEN] && tx_if.level != '0) |-> !tx_if.in_ready)
        else $error("holding register accepted a second byte");
    AST_TWO_STOP: assert property (
        sq_stop1_end |->
        ((st_reg.tx_state == TX_STOP2) == st_reg.lcrh[LCRH_TWO_STOP_SELECT]))
        else $error("stop bit count wrong");
    AST_PARITY_VALUE: assert property (
        (st_reg.tx_state == TX_PARITY) |-> serial_tx_out ==
        ulc_parity(st_reg.tx_char, st_reg.lcrh[LCRH_WORD_LENGTH_SELECT +: 2],
                   st_reg.lcrh[LCRH_EPS], st_reg.lcrh[LCRH_SPS]))
        else $error("parity bit wrong");
    AST_PARITY_SLOT: assert property (
        sq_data_end |-> (st_reg.tx_state ==
        (st_reg.lcrh[LCRH_PEN] ? TX_PARITY : TX_STOP1)))
        else $error("parity slot misplaced");
    AST_STICK: assert property (
        (st_reg.tx_state == TX_PARITY && st_reg.lcrh[LCRH_SPS]) |->
        serial_tx_out == !st_reg.lcrh[LCRH_EPS])
        else $error("stick parity wrong");
    AST_BREAK_LOW: assert property (
        (st_reg.tx_state == TX_BREAK) |-> !serial_tx_out)
        else $error("line not low during break");
    AST_BREAK_ENTRY: assert property (
        $rose(st_reg.tx_state == TX_BREAK) |->
        $past(st_reg.tx_state) == TX_IDLE)
        else $error("break cut a character");
    AST_COMMIT_HOLD: assert property (
        (apb_done && pwrite && paddr == ADDR_IBRD) |=> $stable(st_reg.ibrd))
        else $error("divisor took effect early");
    AST_COMMIT_LOAD: assert property (
        (apb_done && pwrite && paddr == ADDR_LCRH) |=>
        (st_reg.ibrd == $past(st_reg.ibrd_stage) &&
         st_reg.fbrd == $past(st_reg.fbrd_stage)))
        else $error("divisor not committed");
    AST_RESET_VALUES: assert property (
        !post_rst |-> (st_reg.cr == CR_RST && st_reg.lcrh == LCRH_RST))
        else $error("reset values wrong");
    AST_CTS_GATE: assert property (
        $rose(st_reg.tx_state == TX_START) && $past(st_reg.cr[CR_CLEAR_TO_SEND_FLOW_ENABLE])
        |-> !$past(st_reg.cts_filt))
        else $error("started without clear to send");
    AST_RTS_SPACE: assert property (
        $past(st_reg.cr[CR_REQUEST_TO_SEND_FLOW_ENABLE]) |->
        request_to_send_out_n == !$past(rx_if.in_ready))
        else $error("request to send wrong");
    AST_WORD_LEN: assert property (
        (st_reg.tx_state == TX_DATA) |-> st_reg.tx_bit <= last_bit)
        else $error("too many data bits");

endmodule

// *** verification/ulc_terminal.sv ***
`timescale 1ns/1ps
module ulc_terminal (
    input wire logic pclk,
    input wire logic line_in,
    output logic line_out
);
    logic [15:0] seen;
    bit got;
    initial line_out = 1'b1;
    // Samples cells from the start bit; gives up on a dead line
    task automatic grab(input int nb);
        int i;
        i = 0;
        while (line_in !== 1'b0 && i < 2000) begin
            @(posedge pclk);
            i++;
        end
        got = (i < 2000);
        repeat (6) @(posedge pclk);
        for (int k = 0; k < nb; k++) begin
            seen[k] = line_in;
            repeat (16) @(posedge pclk);
        end
    endtask
    task automatic send(input logic [15:0] f, input int nb);
        for (int k = 0; k < nb; k++) begin
            line_out <= f[k];
            repeat (16) @(posedge pclk);
        end
        line_out <= 1'b1;
    endtask
endmodule

// *** verification/tb_ulc_line_control.sv ***
`timescale 1ns/1ps
module tb_ulc_line_control;
    import ulc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic serial_rx_in, clear_to_send_input_n;
    logic serial_tx_out, request_to_send_out_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] b;
    int n, n_errors = 0, tests_run = 0;
    logic [7:0] cases [9] = '{8'h70, 8'h50, 8'h30, 8'h18, 8'h78,
                             8'h72, 8'h36, 8'hf2, 8'hf6};
    ulc_line_control ulc_line_control_i (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .serial_rx_in, .clear_to_send_input_n,
        .serial_tx_out, .request_to_send_out_n
    );
    ulc_terminal ulc_terminal_i (.pclk, .line_in(serial_tx_out),
        .line_out(serial_rx_in));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic hung;
        n_errors++;
        complete_run();
    endtask
    task automatic chk(input string what, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d = '0);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) hung();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic idle;
        int i;
        i = 0;
        do begin
            apb(0, ADDR_FLAGS);
            i++;
        end while (rd[3] !== 1'b0 && i < 400);
        if (i == 400) hung();
    endtask
    // Start, data LSB first, parity, stops, then next start bit
    function automatic int frame(input logic [7:0] c, l,
                                 output logic [15:0] f);
        int k;
        logic p;
        f = '1;
        f[0] = 1'b0;
        p = 1'b0;
        k = 6 + int'(l[6:5]);
        for (int i = 0; i < k - 1; i++) begin
            f[i + 1] = c[i];
            p ^= c[i];
        end
        if (l[1]) begin
            f[k] = l[7] ? ~l[2] : p ^ ~l[2];
            k++;
        end
        k += 1 + int'(l[3]);
        f[k] = 1'b0;
        return k + 1;
    endfunction
    task automatic line(input int nb);
        logic [15:0] m;
        ulc_terminal_i.grab(nb);
        if (!ulc_terminal_i.got) hung();
        m = 16'((32'h1 << nb) - 1);
        chk("frame", 32'(ulc_terminal_i.seen & m), 32'(b & m));
    endtask
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        clear_to_send_input_n = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, ADDR_CR);
        chk("ctrl", rd, 32'h0300);
        apb(0, ADDR_LCRH);
        chk("line", rd, 32'h0);
        apb(0, 12'h100);
        chk("slverr", 32'(er), 32'h1);
        $display("test reset done");
        apb(1, ADDR_LCRH, 32'h70);
        apb(1, ADDR_IBRD, 32'h1);
        apb(1, ADDR_CR, 32'h0301);
        apb(1, ADDR_DATA, 32'hc3);
        repeat (64) @(posedge pclk);
        chk("staged", 32'(serial_tx_out), 32'h1);
        apb(1, ADDR_LCRH, 32'h70);
        n = frame(8'hc3, 8'h70, b);
        line(n - 1);
        idle();
        $display("test commit done");
        foreach (cases[j]) begin
            apb(1, ADDR_CR, 32'h0300);
            apb(1, ADDR_LCRH, 32'(cases[j]));
            apb(1, ADDR_CR, 32'h0301);
            apb(1, ADDR_DATA, 32'hc3);
            apb(1, ADDR_DATA, 32'hc3);
            n = frame(8'hc3, cases[j], b);
            line(n);
            idle();
        end
        $display("test formats done");
        apb(1, ADDR_CR, 32'h0300);
        apb(1, ADDR_LCRH, 32'h66);
        apb(1, ADDR_CR, 32'h4301);
        repeat (2) @(posedge pclk);
        chk("room", 32'(request_to_send_out_n), 32'h0);
        n = frame(8'hc3, 8'h66, b);
        ulc_terminal_i.send(b, n - 1);
        repeat (8) @(posedge pclk);
        chk("full", 32'(request_to_send_out_n), 32'h1);
        apb(0, ADDR_DATA);
        chk("rx good", rd, 32'hc3);
        repeat (2) @(posedge pclk);
        chk("room", 32'(request_to_send_out_n), 32'h0);
        ulc_terminal_i.send(b ^ 16'h0200, n - 1);
        repeat (8) @(posedge pclk);
        apb(0, ADDR_DATA);
        chk("rx bad", rd, 32'h1c3);
        $display("test receive done");
        apb(1, ADDR_CR, 32'h0300);
        apb(1, ADDR_LCRH, 32'h70);
        clear_to_send_input_n <= 1'b1;
        apb(1, ADDR_CR, 32'h8301);
        apb(1, ADDR_DATA, 32'hc3);
        repeat (64) @(posedge pclk);
        chk("cts hold", 32'(serial_tx_out), 32'h1);
        clear_to_send_input_n <= 1'b0;
        n = frame(8'hc3, 8'h70, b);
        line(n - 1);
        idle();
        $display("test flow done");
        // Break comes last: FIFO contents are not trusted after it
        apb(1, ADDR_DATA, 32'hc3);
        apb(1, ADDR_LCRH, 32'h71);
        line(n - 1);
        repeat (400) @(posedge pclk);
        chk("break", 32'(serial_tx_out), 32'h0);
        apb(1, ADDR_LCRH, 32'h70);
        repeat (4) @(posedge pclk);
        chk("break off", 32'(serial_tx_out), 32'h1);
        $display("test break done");
        complete_run();
    end
endmodule
